// ===== rtl/ibc_pkg.sv
// Shared constants and types for the I2C bus-condition detector.
// Assumes a single 250 MHz system clock and a synchronous active-high reset.
`default_nettype none

package ibc_pkg;

    // ==========================================================
    // Widths
    localparam int unsigned BYTE_W      = 8;
    localparam int unsigned ADDR_REGS   = 2;
    localparam int unsigned SYNC_STAGES = 2;
    localparam int unsigned HOLD_CNT_W  = 8;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS  = 4;
    localparam int unsigned HOLD_LONG_NS   = 300;
    localparam int unsigned HOLD_SHORT_NS  = 100;
    localparam int unsigned HOLD_LONG_CYC  =
        (HOLD_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HOLD_SHORT_CYC =
        (HOLD_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [HOLD_CNT_W-1:0] HOLD_LONG_CNT  = HOLD_CNT_W'(HOLD_LONG_CYC);
    localparam logic [HOLD_CNT_W-1:0] HOLD_SHORT_CNT = HOLD_CNT_W'(HOLD_SHORT_CYC);
    localparam logic [HOLD_CNT_W-1:0] HOLD_CNT_MAX   = 8'hff;

    // ==========================================================
    // Address byte fields
    localparam int unsigned RW_BIT     = 0;
    localparam int unsigned TEN_HI_MSB = 2;
    localparam int unsigned TEN_HI_LSB = 1;
    localparam logic [4:0]  TEN_PREFIX = 5'h1e;
    localparam int unsigned HI_REG_IDX = 0;
    localparam int unsigned LO_REG_IDX = 1;

    // ==========================================================
    // Address phase tracking
    typedef enum logic [1:0] {
        AS_IDLE,
        AS_HIGH,
        AS_LOW,
        AS_DATA
    } ibc_addr_e;

endpackage

`default_nettype wire

// ===== rtl/ibc_sync.sv
// Two-stage synchroniser for the bus pins.
// Assumes inputs are asynchronous to mclk; outputs are safe to decode.
`timescale 1ns/1ns
`default_nettype none

module ibc_sync #(
    parameter int unsigned WIDTH = 2
) (
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync
);
    import ibc_pkg::*;

    logic [WIDTH-1:0] meta_q;

    // Idle bus is high, so both stages reset high to avoid a false Start
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            meta_q   <= {WIDTH{1'b1}};
            pin_sync <= {WIDTH{1'b1}};
        end else begin
            meta_q   <= pin_in;
            pin_sync <= meta_q;
        end
    end

endmodule

`default_nettype wire

// ===== rtl/ibc_addr_match.sv
// Address comparison against the slave address registers.
// Assumes the byte is stable while its valid strobe is high.
`timescale 1ns/1ns
`default_nettype none

module ibc_addr_match (
    input  wire logic [ibc_pkg::ADDR_REGS-1:0][ibc_pkg::BYTE_W-1:0] addr_regs,
    input  wire logic [ibc_pkg::BYTE_W-1:0]                         rx_byte,
    output logic                                                    match_7bit,
    output logic                                                    match_hi,
    output logic                                                    match_lo
);
    import ibc_pkg::*;

    logic [ADDR_REGS-1:0] hit;
    logic [BYTE_W-1:0]    hi_pattern;

    // The direction bit never takes part in a 7-bit compare
    for (genvar i = 0; i < ADDR_REGS; i++) begin : g_reg
        assign hit[i] = rx_byte[BYTE_W-1:1] == addr_regs[i][BYTE_W-1:1];
    end
    assign match_7bit = |hit;

    assign hi_pattern = {TEN_PREFIX,
                         addr_regs[HI_REG_IDX][TEN_HI_MSB:TEN_HI_LSB],
                         1'b0};
    assign match_hi = rx_byte[BYTE_W-1:1] == hi_pattern[BYTE_W-1:1];
    assign match_lo = rx_byte == addr_regs[LO_REG_IDX];

endmodule

`default_nettype wire

// ===== rtl/ibc_cond_det.sv
// Bus-condition logic of an I2C port: Start/Stop/Restart, collisions,
// idle state, 10-bit prior match, SDA hold time and Start/Stop interrupts.
// Assumes a byte shifter on mclk supplies received bytes and the bit to send.
`timescale 1ns/1ns
`default_nettype none

module ibc_cond_det (
    input  wire logic                                        mclk,
    input  wire logic                                        sys_rst,
    input  wire logic                                        sda_in,
    input  wire logic                                        scl_in,
    output logic                                             sda_out,
    output logic                                             sda_oe,
    output logic                                             scl_out,
    output logic                                             scl_oe,
    input  wire logic                                        sda_hold_select,
    input  wire logic                                        start_irq_enable,
    input  wire logic                                        stop_irq_enable,
    input  wire logic                                        ss_irq_mode,
    input  wire logic                                        ten_bit_mode,
    input  wire logic [ibc_pkg::ADDR_REGS-1:0][ibc_pkg::BYTE_W-1:0] slave_address_regs,
    input  wire logic [ibc_pkg::BYTE_W-1:0]                  rx_byte,
    input  wire logic                                        rx_byte_valid,
    input  wire logic                                        tx_enable,
    input  wire logic                                        tx_bit,
    input  wire logic                                        gen_start,
    input  wire logic                                        scl_release,
    input  wire logic                                        irq_flag_clear,
    output logic                                             start_seen,
    output logic                                             stop_seen,
    output logic                                             restart_seen,
    output logic                                             transfer_reset,
    output logic                                             bus_active,
    output logic                                             bus_idle,
    output logic                                             bus_collision,
    output logic                                             start_collision,
    output logic                                             addr_matched,
    output logic                                             read_request,
    output logic                                             prior_match,
    output logic                                             port_irq_flag
);
    import ibc_pkg::*;

    // ==========================================================
    // Pin synchronisation and edges
    logic [1:0] pins_s;
    logic       sda_s;
    logic       scl_s;
    logic       sda_p_q;
    logic       scl_p_q;

    ibc_sync #(
        .WIDTH (2)
    ) u_sync (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .pin_in   ({sda_in, scl_in}),
        .pin_sync (pins_s)
    );

    assign sda_s = pins_s[1];
    assign scl_s = pins_s[0];

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sda_p_q <= 1'b1;
            scl_p_q <= 1'b1;
        end else begin
            sda_p_q <= sda_s;
            scl_p_q <= scl_s;
        end
    end

    logic sda_fall;
    logic sda_rise;
    logic scl_fall;
    logic scl_rise;
    logic scl_high;
    logic start_cond;
    logic stop_cond;

    assign sda_fall   = sda_p_q & ~sda_s;
    assign sda_rise   = ~sda_p_q & sda_s;
    assign scl_fall   = scl_p_q & ~scl_s;
    assign scl_rise   = ~scl_p_q & scl_s;
    assign scl_high   = scl_p_q & scl_s;
    assign start_cond = sda_fall & scl_high;
    assign stop_cond  = sda_rise & scl_high;

    // ==========================================================
    // Condition classification
    logic active_q;
    logic low_seen_q;
    logic stop_ok;
    logic start_det;
    logic restart_det;
    logic stop_det;

    // A Stop or Restart needs an SCL low period since the last Start
    assign stop_ok     = active_q & low_seen_q;
    assign start_det   = start_cond & ~stop_ok;
    assign restart_det = start_cond & stop_ok;
    assign stop_det    = stop_cond & stop_ok;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            active_q <= 1'b0;
        end else if (start_cond) begin
            active_q <= 1'b1;
        end else if (stop_det) begin
            active_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst || start_cond) begin
            low_seen_q <= 1'b0;
        end else if (active_q && !scl_s) begin
            low_seen_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            start_seen     <= 1'b0;
            stop_seen      <= 1'b0;
            restart_seen   <= 1'b0;
            transfer_reset <= 1'b0;
            bus_idle       <= 1'b0;
        end else begin
            start_seen     <= start_det;
            stop_seen      <= stop_det;
            restart_seen   <= restart_det;
            transfer_reset <= start_cond;
            bus_idle       <= ~active_q & sda_s & scl_s;
        end
    end

    assign bus_active = active_q;

    // ==========================================================
    // Address phase and 10-bit prior match
    ibc_addr_e addr_q;
    logic      match_7bit;
    logic      match_hi;
    logic      match_lo;
    logic      rw_read;

    ibc_addr_match u_match (
        .addr_regs  (slave_address_regs),
        .rx_byte    (rx_byte),
        .match_7bit (match_7bit),
        .match_hi   (match_hi),
        .match_lo   (match_lo)
    );

    assign rw_read = rx_byte[RW_BIT];

    // Start and Restart both return to the address phase
    always_ff @(posedge mclk) begin
        if (sys_rst || stop_det) begin
            addr_q <= AS_IDLE;
        end else if (start_cond) begin
            addr_q <= AS_HIGH;
        end else if (rx_byte_valid) begin
            unique case (addr_q)
                AS_HIGH: begin
                    if (!ten_bit_mode) begin
                        addr_q <= match_7bit ? AS_DATA : AS_IDLE;
                    end else if (match_hi && !rw_read) begin
                        addr_q <= AS_LOW;
                    end else if (match_hi && prior_match) begin
                        addr_q <= AS_DATA;
                    end else begin
                        addr_q <= AS_IDLE;
                    end
                end
                AS_LOW:  addr_q <= match_lo ? AS_DATA : AS_IDLE;
                AS_DATA: addr_q <= AS_DATA;
                AS_IDLE: addr_q <= AS_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst || stop_det) begin
            prior_match <= 1'b0;
        end else if (rx_byte_valid && ten_bit_mode) begin
            if (addr_q == AS_HIGH && (!match_hi || !rw_read)) begin
                prior_match <= 1'b0;
            end else if (addr_q == AS_LOW && match_lo) begin
                prior_match <= 1'b1;
            end
        end
    end

    logic hi_read_ok;
    assign hi_read_ok = addr_q == AS_HIGH && rx_byte_valid && ten_bit_mode
                        && match_hi && rw_read && prior_match;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            addr_matched <= 1'b0;
        end else begin
            addr_matched <= rx_byte_valid
                && ((addr_q == AS_HIGH && !ten_bit_mode && match_7bit)
                    || (addr_q == AS_LOW && match_lo)
                    || hi_read_ok);
        end
    end

    // Read direction stands until the next Start, Restart or Stop
    always_ff @(posedge mclk) begin
        if (sys_rst || start_cond || stop_det) begin
            read_request <= 1'b0;
        end else if (hi_read_ok) begin
            read_request <= 1'b1;
        end else if (addr_q == AS_HIGH && rx_byte_valid && !ten_bit_mode
                     && match_7bit && rw_read) begin
            read_request <= 1'b1;
        end
    end

    // Clock stretch after a 10-bit read header until the shifter has loaded data to send
    logic scl_hold_q;
    always_ff @(posedge mclk) begin
        if (sys_rst || start_cond || stop_det || scl_release) begin
            scl_hold_q <= 1'b0;
        end else if (hi_read_ok) begin
            scl_hold_q <= 1'b1;
        end
    end

    assign scl_out = 1'b0;
    assign scl_oe  = scl_hold_q;

    // ==========================================================
    // SDA hold time and data drive
    logic [HOLD_CNT_W-1:0] hold_cnt_q;
    logic                  data_level_q;
    logic                  start_drive_q;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            hold_cnt_q <= '0;
        end else if (scl_fall) begin
            hold_cnt_q <= sda_hold_select ? HOLD_LONG_CNT : HOLD_SHORT_CNT;
        end else if (hold_cnt_q != '0) begin
            hold_cnt_q <= hold_cnt_q - 1'b1;
        end
    end

    // New data only lands once the hold window has expired with SCL low
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            data_level_q <= 1'b1;
        end else if (hold_cnt_q == '0 && !scl_s && !scl_fall) begin
            data_level_q <= tx_bit;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe  = (tx_enable & ~data_level_q) | start_drive_q;

    // ==========================================================
    // Start generation and collisions
    // Pin sampling lags two cycles, so a master that pulled SDA low just
    // before our request can slip through; the start_collision check only looks at SDA while start_drive_q is still low.
    always_ff @(posedge mclk) begin
        if (sys_rst || scl_fall) begin
            start_drive_q <= 1'b0;
        end else if (gen_start && sda_s && scl_s) begin
            start_drive_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            start_collision <= 1'b0;
            bus_collision   <= 1'b0;
        end else begin
            start_collision <= gen_start && !start_drive_q && !sda_s;
            bus_collision   <= (gen_start && !start_drive_q && !sda_s)
                               || (scl_rise && tx_enable && data_level_q && !sda_s);
        end
    end

    // ==========================================================
    // Port interrupt flag; a set in the clearing cycle wins
    logic irq_set;
    assign irq_set = ((start_det | restart_det) & (ss_irq_mode | start_irq_enable))
                     | (stop_det & (ss_irq_mode | stop_irq_enable));

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            port_irq_flag <= 1'b0;
        end else if (irq_set) begin
            port_irq_flag <= 1'b1;
        end else if (irq_flag_clear) begin
            port_irq_flag <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    logic [HOLD_CNT_W-1:0] since_fall_q;
    logic                  sel_at_fall_q;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            since_fall_q  <= HOLD_CNT_MAX;
            sel_at_fall_q <= 1'b0;
        end else if (scl_fall) begin
            since_fall_q  <= '0;
            sel_at_fall_q <= sda_hold_select;
        end else if (since_fall_q != HOLD_CNT_MAX) begin
            since_fall_q <= since_fall_q + 1'b1;
        end
    end

    a_hold_long_time: assert property (@(posedge mclk) disable iff (sys_rst)
        $changed(data_level_q) && sel_at_fall_q |-> since_fall_q >= HOLD_LONG_CNT)
        else $error("SDA changed inside the long hold window");

    a_start_seen_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
        start_cond && !stop_ok |=> start_seen && bus_active)
        else $error("Start not reported");

    a_start_coll_flag: assert property (@(posedge mclk) disable iff (sys_rst)
        gen_start && !start_drive_q && !sda_s |=> start_collision && bus_collision
        && !start_drive_q)
        else $error("Start collision missed");

    a_stop_ends_bus: assert property (@(posedge mclk) disable iff (sys_rst)
        stop_cond && stop_ok |=> stop_seen && !bus_active ##1 !prior_match)
        else $error("Stop not handled");

    a_stop_needs_low: assert property (@(posedge mclk) disable iff (sys_rst)
        (stop_seen || restart_seen) |-> $past(low_seen_q) && $past(scl_s))
        else $error("Stop or Restart without SCL low period");

    a_restart_resets: assert property (@(posedge mclk) disable iff (sys_rst)
        restart_seen |-> transfer_reset ##0 addr_q == AS_HIGH)
        else $error("Restart did not reset address phase");

    a_ten_read_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        hi_read_ok && !scl_release |=> scl_oe && read_request && addr_matched)
        else $error("10-bit read not held");

    a_prior_set: assert property (@(posedge mclk) disable iff (sys_rst)
        rx_byte_valid && ten_bit_mode && addr_q == AS_LOW && match_lo && !stop_det
        && !start_cond |=> prior_match && addr_q == AS_DATA)
        else $error("Prior match not set");

    a_irq_on_start: assert property (@(posedge mclk) disable iff (sys_rst)
        start_seen && $past(start_irq_enable || ss_irq_mode) |-> port_irq_flag)
        else $error("Start interrupt missing");

    a_irq_off_plain: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(port_irq_flag) && stop_seen && !restart_seen && !start_seen
        |-> $past(stop_irq_enable || ss_irq_mode))
        else $error("Stop interrupt raised while disabled");

    a_coll_high_out: assert property (@(posedge mclk) disable iff (sys_rst)
        scl_rise && tx_enable && data_level_q && !sda_s |=> bus_collision)
        else $error("Bus collision missed");

    a_idle_bus_lines: assert property (@(posedge mclk) disable iff (sys_rst)
        bus_idle |-> $past(!active_q && sda_s && scl_s))
        else $error("Idle reported on busy bus");

endmodule

`default_nettype wire

// ===== testbench/ibc_master_model.sv
// Behavioural I2C master on the bus pins; a released line floats high.
// Assumes the bench wires each line open-drain with a pull-up.
`timescale 1ns/1ns
`default_nettype none

module ibc_master_model (
    input  wire logic mclk,
    output logic      m_sda,
    output logic      m_scl
);
    initial begin
        m_sda = 1'b1;
        m_scl = 1'b1;
    end
    // ==========================================
    // Line steps; 8 cycles is half of a 64 ns link period, larger n is slow
    task automatic sda_to(input logic v, input int n = 8);
        @(posedge mclk);
        m_sda <= v;
        repeat (n) @(posedge mclk);
    endtask
    task automatic scl_to(input logic v, input int n = 8);
        @(posedge mclk);
        m_scl <= v;
        repeat (n) @(posedge mclk);
    endtask
    // ==========================================
    // Conditions
    task automatic start();
        sda_to(1'b0);
    endtask
    task automatic stop();
        scl_to(1'b0);
        sda_to(1'b0);
        scl_to(1'b1);
        sda_to(1'b1);
    endtask
    task automatic restart();
        scl_to(1'b0);
        sda_to(1'b1);
        scl_to(1'b1);
        sda_to(1'b0);
    endtask
endmodule
`default_nettype wire

// ===== testbench/ibc_cond_det_tb_top.sv
// Self-checking bench for the I2C bus-condition detector.
// Assumes the master model drives the pins; the bench plays the byte shifter.
`timescale 1ns/1ns
`default_nettype none

module ibc_cond_det_tb_top;
    import ibc_pkg::*;
    logic                       mclk = 1'b0;
    logic                       sys_rst = 1'b1;
    logic                       m_sda, m_scl, sda_oe, scl_oe;
    logic                       start_seen, stop_seen, restart_seen, transfer_reset;
    logic                       bus_active, bus_idle, bus_collision, start_collision;
    logic                       addr_matched, read_request, prior_match, port_irq_flag;
    logic                       sda_hold_select, start_irq_enable, stop_irq_enable;
    logic                       ss_irq_mode, ten_bit_mode, rx_byte_valid, tx_enable, tx_bit;
    logic [ADDR_REGS-1:0][7:0]  slave_address_regs;
    logic [7:0]                 rx_byte, rnd, lo;
    logic [1:0]                 a98;
    logic [2:0]                 pls;
    int                         error_cnt, num_checks, n, n_st, n_sp, n_rs, n_tr, n_bc, n_col;
    int                         n_am;
    // Open-drain lines with pull-ups
    wire                        sda_in = m_sda & ~sda_oe;
    wire                        scl_in = m_scl & ~scl_oe;

    always #2 mclk = ~mclk;

    ibc_master_model mdl (.mclk, .m_sda, .m_scl);

    ibc_cond_det dut (
        .mclk, .sys_rst, .sda_in, .scl_in, .sda_out(), .sda_oe, .scl_out(), .scl_oe,
        .sda_hold_select, .start_irq_enable, .stop_irq_enable, .ss_irq_mode, .ten_bit_mode,
        .slave_address_regs, .rx_byte, .rx_byte_valid, .tx_enable, .tx_bit,
        .gen_start(pls[0]), .scl_release(pls[1]), .irq_flag_clear(pls[2]),
        .start_seen, .stop_seen, .restart_seen, .transfer_reset, .bus_active, .bus_idle,
        .bus_collision, .start_collision, .addr_matched, .read_request, .prior_match,
        .port_irq_flag
    );

    // ==========================================
    // Event counters; pulses last one cycle so each is seen once
    always @(posedge mclk) begin
        n_st += (start_seen === 1'b1);
        n_sp += (stop_seen === 1'b1);
        n_rs += (restart_seen === 1'b1);
        n_tr += (transfer_reset === 1'b1);
        n_bc += (bus_collision === 1'b1);
        n_col += (start_collision === 1'b1);
        n_am += (addr_matched === 1'b1);
    end

    // ==========================================
    // Helpers
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Index 0 asks for a Start, 1 drops the SCL hold, 2 clears the irq flag
    task automatic pulse(input int k);
        @(posedge mclk);
        pls[k] <= 1'b1;
        @(posedge mclk);
        pls[k] <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
    task automatic rx(input logic [7:0] b);
        @(posedge mclk);
        rx_byte <= b;
        rx_byte_valid <= 1'b1;
        @(posedge mclk);
        rx_byte_valid <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        results();
    end

    initial begin
        {sda_hold_select, start_irq_enable, stop_irq_enable, ss_irq_mode} = 4'h0;
        {ten_bit_mode, rx_byte_valid, tx_enable, tx_bit, pls} = 7'h00;
        slave_address_regs = '0;
        rx_byte = 8'h00;
        rnd = 8'h61;
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("idle", {bus_idle, bus_active}, 8'h02);
        start_irq_enable <= 1'b1;
        mdl.start();
        chk("start", {n_st[3:0], 2'b0, bus_idle, bus_active}, 8'h11);
        chk("irq", port_irq_flag, 8'h01);
        mdl.sda_to(1'b1);
        chk("early stop", {n_sp[3:0], 3'b0, bus_active}, 8'h01);
        mdl.sda_to(1'b0);
        chk("start again", {n_st[3:0], n_rs[3:0]}, 8'h20);
        $display("test conditions finished");
        // 10-bit write match, then Restart and read; only reg0 bits 2:1 matter
        rnd = lfsr(rnd);
        a98 = rnd[2:1];
        rnd = lfsr(rnd);
        lo = lfsr(rnd);
        ten_bit_mode <= 1'b1;
        slave_address_regs <= {lo, rnd[7:3], a98, ~rnd[0]};
        rx({5'h1e, a98, 1'b0});
        rx(lo);
        chk("prior", {prior_match, read_request}, 8'h02);
        mdl.restart();
        chk("restart", {n_rs[3:0], n_tr[3:0]}, 8'h13);
        rx({5'h1e, a98, 1'b1});
        chk("read", {prior_match, read_request, scl_oe}, 8'h07);
        pulse(1);
        mdl.stop();
        chk("stop", {n_sp[3:0], 1'b0, prior_match, bus_active, read_request}, 8'h10);
        $display("test ten bit finished");
        // 7-bit read: direction bit ignored in the compare, Restart drops the read
        ten_bit_mode <= 1'b0;
        mdl.start();
        rx({slave_address_regs[0][7:1], 1'b1});
        chk("seven", {n_am[3:0], 3'b0, read_request}, 8'h31);
        pulse(2);
        mdl.restart();
        chk("restart irq", {port_irq_flag, read_request}, 8'h02);
        mdl.stop();
        $display("test seven bit finished");
        for (int m = 0; m < 8; m++) begin
            {ss_irq_mode, start_irq_enable, stop_irq_enable} <= 3'(m);
            pulse(2);
            mdl.start();
            chk("irq start", port_irq_flag, 8'(m[2] | m[1]));
            pulse(2);
            mdl.stop();
            chk("irq stop", port_irq_flag, 8'(m[2] | m[0]));
        end
        $display("test interrupts finished");
        mdl.sda_to(1'b0);
        pulse(0);
        chk("start coll", {n_col[3:0], n_bc[3:0]}, 8'h11);
        for (int h = 1; h >= 0; h--) begin
            sda_hold_select <= h[0];
            tx_enable <= 1'b1;
            tx_bit <= 1'b0;
            n = 0;
            fork
                mdl.scl_to(1'b0, 120);
                begin
                    @(negedge scl_in);
                    while (sda_oe !== 1'b1 && n < 200) begin
                        @(posedge mclk);
                        n++;
                    end
                end
            join
            chk("hold", 8'(n >= (h ? HOLD_LONG_CYC : HOLD_SHORT_CYC)
                && n < (h ? 200 : HOLD_LONG_CYC)), 8'h01);
            // Send a high while the master keeps SDA low
            tx_bit <= 1'b1;
            mdl.scl_to(1'b1);
            chk("data coll", 8'(n_bc), 8'(3 - h));
        end
        tx_enable <= 1'b0;
        mdl.stop();
        $display("test collisions finished");
        results();
    end
endmodule
`default_nettype wire
